// ---- rtl/gpp_params.svh ----
// timing constants and reset values for the pulse/debounce port
// assumes a 100 MHz system clock
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH

`define GPP_CLK_HZ 100000000
`define GPP_MIN_PULSE_MS 50
`define GPP_TOGGLE_MS 20
`define GPP_CONT_HZ 24
// least width rounds down, exact here
`define GPP_MIN_PULSE_CYC ((`GPP_CLK_HZ / 1000) * `GPP_MIN_PULSE_MS)
`define GPP_TOGGLE_CYC ((`GPP_CLK_HZ / 1000) * `GPP_TOGGLE_MS)
// half period of the continuous toggle, rounded down
`define GPP_CONT_HALF_CYC (`GPP_CLK_HZ / (2 * `GPP_CONT_HZ))
`define GPP_OUT_RST 8'h00
`define GPP_RSVD_MASK 8'h0f

`endif

// ---- rtl/gpp_pkg.sv ----
// types shared by the pulse/debounce port
// assumes the params header defines the numbers
`default_nettype none

package gpp_pkg;

  // per-output software command
  typedef enum logic [2:0] {
    GPP_CMD_NONE = 3'h0,
    GPP_CMD_FALL = 3'h1,
    GPP_CMD_RISE = 3'h2,
    GPP_CMD_TOG = 3'h3,
    GPP_CMD_CONT = 3'h4
  } gpp_cmd_t;

  // per-output mode, one-hot
  typedef enum logic [2:0] {
    GPP_M_STEADY = 3'h1,
    GPP_M_PULSE = 3'h2,
    GPP_M_CONT = 3'h4
  } gpp_mode_t;

  // command strobe with its target
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    gpp_cmd_t cmd;
  } gpp_req_t;

endpackage

`default_nettype wire

// ---- rtl/gpp_port.sv ----
// eight filtered macro trigger inputs and eight commanded outputs
// assumes inputs synchronous to CLK; one command per cycle
`timescale 1ns/1ps
`include "gpp_params.svh"
`default_nettype none

module gpp_port
  import gpp_pkg::*;
#(
  parameter int NCH = 8,
  parameter int MIN_PULSE_CYC = `GPP_MIN_PULSE_CYC,
  parameter int TOGGLE_CYC = `GPP_TOGGLE_CYC,
  parameter int CONT_HALF_CYC = `GPP_CONT_HALF_CYC,
  parameter bit RSVD_VARIANT = 1'b0,
  parameter bit SLEEP_VARIANT = 1'b0,
  parameter int SLEEP_ENTER_CH = 0,
  parameter int SLEEP_EXIT_CH = 1
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [NCH-1:0] TRIG_IN,
  input wire gpp_req_t CMD,
  input wire logic SLEEP,
  input wire logic POWER_OFF,
  output logic [NCH-1:0] TRIG_EVENT,
  output logic [NCH-1:0] OUT_LEVEL,
  output logic [NCH-1:0] OUT_OE,
  output logic SLEEP_ENTER_REQ,
  output logic SLEEP_EXIT_REQ
);

  localparam int CW = $clog2(MIN_PULSE_CYC + 1);
  localparam int TW = $clog2(TOGGLE_CYC + CONT_HALF_CYC + 1);
  localparam logic [NCH-1:0] RSVD = RSVD_VARIANT ?
    NCH'(`GPP_RSVD_MASK) : '0;

  // ------------------------------------------------------------
  // input pulse filter
  // ------------------------------------------------------------
  logic [CW-1:0] width_q [NCH];
  logic [NCH-1:0] fired_q;
  logic [NCH-1:0] event_q;

  // per-channel width counter; event once per pulse, at the limit
  // independent filters
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      for (int i = 0; i < NCH; i++)
        width_q[i] <= '0;
      fired_q <= '0;
      event_q <= '0;
    end
    else if (CE)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        event_q[i] <= 1'b0;
        if (!TRIG_IN[i])
        begin
          width_q[i] <= '0;
          fired_q[i] <= 1'b0;
        end
        else if (!fired_q[i])
        begin
          if (width_q[i] == CW'(MIN_PULSE_CYC - 1))
          begin
            fired_q[i] <= 1'b1;
            event_q[i] <= 1'b1;
          end
          width_q[i] <= width_q[i] + 1'b1;
        end
      end
    end
  end

  assign TRIG_EVENT = event_q;

  // ------------------------------------------------------------
  // sleep requests from fixed macros
  // ------------------------------------------------------------
  logic sleep_ent_q;
  logic sleep_ext_q;

  // sleep via port only on one variant
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sleep_ent_q <= 1'b0;
      sleep_ext_q <= 1'b0;
    end
    else if (CE)
    begin
      sleep_ent_q <= SLEEP_VARIANT && event_q[SLEEP_ENTER_CH];
      sleep_ext_q <= SLEEP_VARIANT && event_q[SLEEP_EXIT_CH];
    end
  end

  assign SLEEP_ENTER_REQ = sleep_ent_q;
  assign SLEEP_EXIT_REQ = sleep_ext_q;

  // ------------------------------------------------------------
  // output command engine
  // ------------------------------------------------------------
  logic [NCH-1:0] lvl_q;
  logic [NCH-1:0] base_q;
  logic [NCH-1:0] oe_q;
  gpp_mode_t mode_q [NCH];
  logic [TW-1:0] tmr_q [NCH];

  // command addressed to channel i and not reserved
  function automatic logic hit(input gpp_req_t r, input int i);
    hit = r.valid && (int'(r.chan) == i) && !RSVD[i];
  endfunction

  // one process owns level, mode and timer; a command wins over timers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      lvl_q <= NCH'(`GPP_OUT_RST);
      base_q <= NCH'(`GPP_OUT_RST);
      oe_q <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        mode_q[i] <= GPP_M_STEADY;
        tmr_q[i] <= '0;
      end
    end
    else if (CE)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (SLEEP || POWER_OFF)
        begin
          oe_q[i] <= 1'b0;
          mode_q[i] <= GPP_M_STEADY;
          tmr_q[i] <= '0;
        end
        else if (hit(CMD, i))
        begin
          case (CMD.cmd)
            GPP_CMD_FALL:
            begin
              lvl_q[i] <= 1'b0;
              base_q[i] <= 1'b0;
              oe_q[i] <= 1'b1;
              mode_q[i] <= GPP_M_STEADY;
            end
            GPP_CMD_RISE:
            begin
              lvl_q[i] <= 1'b1;
              base_q[i] <= 1'b1;
              oe_q[i] <= 1'b1;
              mode_q[i] <= GPP_M_STEADY;
            end
            // single pulse from the settled level
            GPP_CMD_TOG:
            begin
              base_q[i] <= (mode_q[i] == GPP_M_PULSE) ? base_q[i] : lvl_q[i];
              lvl_q[i] <= (mode_q[i] == GPP_M_PULSE) ? ~base_q[i] : ~lvl_q[i];
              oe_q[i] <= 1'b1;
              mode_q[i] <= GPP_M_PULSE;
              tmr_q[i] <= TW'(TOGGLE_CYC - 1);
            end
            GPP_CMD_CONT:
            begin
              if (mode_q[i] != GPP_M_CONT)
              begin
                lvl_q[i] <= ~lvl_q[i];
                oe_q[i] <= 1'b1;
                mode_q[i] <= GPP_M_CONT;
                tmr_q[i] <= TW'(CONT_HALF_CYC - 1);
              end
            end
            default:
            begin
              mode_q[i] <= mode_q[i];
            end
          endcase
        end
        else
        begin
          case (mode_q[i])
            GPP_M_PULSE:
            begin
              if (tmr_q[i] == '0)
              begin
                lvl_q[i] <= base_q[i];
                mode_q[i] <= GPP_M_STEADY;
              end
              else
                tmr_q[i] <= tmr_q[i] - 1'b1;
            end
            GPP_M_CONT:
            begin
              if (tmr_q[i] == '0)
              begin
                lvl_q[i] <= ~lvl_q[i];
                tmr_q[i] <= TW'(CONT_HALF_CYC - 1);
              end
              else
                tmr_q[i] <= tmr_q[i] - 1'b1;
            end
            GPP_M_STEADY:
            begin
              tmr_q[i] <= '0;
            end
            default:
            begin
              mode_q[i] <= GPP_M_STEADY;
            end
          endcase
        end
      end
    end
  end

  // released lines keep their last level on OUT_LEVEL; the pull sets the wire
  assign OUT_LEVEL = lvl_q;
  assign OUT_OE = oe_q;

  // ------------------------------------------------------------
  // checks, one set per channel plus two port-wide ones
  // ------------------------------------------------------------
  // every channel is watched, so reserved ones are checked as well
  for (genvar g = 0; g < NCH; g++)
  begin : g_chk
    property p_filter_min;
      @(posedge CLK) disable iff (RST)
      $rose(event_q[g]) |-> $past(TRIG_IN[g]) && !$past(fired_q[g]);
    endproperty
    a_filter_min: assert property (p_filter_min)
      else $error("event without filtered pulse");

    property p_event_pulse;
      @(posedge CLK) disable iff (RST)
      event_q[g] && CE |=> !event_q[g];
    endproperty
    a_event_pulse: assert property (p_event_pulse)
      else $error("event longer than one cycle");

    property p_fall;
      @(posedge CLK) disable iff (RST)
      CE && !SLEEP && !POWER_OFF && hit(CMD, g) && CMD.cmd == GPP_CMD_FALL
      |=> !lvl_q[g] && oe_q[g] && mode_q[g] == GPP_M_STEADY;
    endproperty
    a_fall: assert property (p_fall)
      else $error("fall command did not drive low");

    property p_rise;
      @(posedge CLK) disable iff (RST)
      CE && !SLEEP && !POWER_OFF && hit(CMD, g) && CMD.cmd == GPP_CMD_RISE
      |=> lvl_q[g] && oe_q[g];
    endproperty
    a_rise: assert property (p_rise)
      else $error("rise command did not drive high");

    property p_tog;
      @(posedge CLK) disable iff (RST)
      CE && !SLEEP && !POWER_OFF && hit(CMD, g) && CMD.cmd == GPP_CMD_TOG
      && mode_q[g] == GPP_M_STEADY |=> lvl_q[g] != $past(lvl_q[g]);
    endproperty
    a_tog: assert property (p_tog)
      else $error("toggle did not invert");

    property p_rsvd;
      @(posedge CLK) disable iff (RST)
      RSVD[g] |-> oe_q[g] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd)
      else $error("reserved output driven");

    c_event: cover property (@(posedge CLK) disable iff (RST) event_q[g]);
    c_pulse: cover property (@(posedge CLK) disable iff (RST)
      mode_q[g] == GPP_M_PULSE);
    c_cont: cover property (@(posedge CLK) disable iff (RST)
      mode_q[g] == GPP_M_CONT);
    c_rel: cover property (@(posedge CLK) disable iff (RST)
      $fell(oe_q[g]));
  end

  property p_release;
    @(posedge CLK) disable iff (RST)
    CE && (SLEEP || POWER_OFF) |=> oe_q == '0;
  endproperty
  a_release: assert property (p_release)
    else $error("outputs not released");

  // a request only on the sleep variant and only right after its event
  property p_sleep_var;
    @(posedge CLK) disable iff (RST)
    $past(CE) && (sleep_ent_q || sleep_ext_q) |-> SLEEP_VARIANT
    && sleep_ent_q == $past(event_q[SLEEP_ENTER_CH])
    && sleep_ext_q == $past(event_q[SLEEP_EXIT_CH]);
  endproperty
  a_sleep_var: assert property (p_sleep_var)
    else $error("sleep request on wrong variant");

endmodule

`default_nettype wire

// ---- dv/gpp_equip.sv ----
// external equipment: pulse source on the inputs, pulled load on outputs
// assumes the bench sets drive_mask just after clock edges
`timescale 1ns/1ps
`default_nettype none

module gpp_equip
#(
  parameter logic [7:0] PULL = 8'hf0
)
(
  input wire logic clk,
  input wire logic [7:0] drive_mask,
  input wire logic [7:0] out_level,
  input wire logic [7:0] out_oe,
  output logic [7:0] trig_line,
  output var logic [7:0] pin_level
);
  // ---------------------------------------------
  // input lines and output load
  // ---------------------------------------------
  // square edges only
  // lines move on the clock edge, so no slow ramps reach the filter
  always_ff @(posedge clk)
  begin
    trig_line <= drive_mask;
  end

  // released pins sit at the pull level, not the last driven value
  assign pin_level = (out_oe & out_level) | (~out_oe & PULL);
endmodule

`default_nettype wire

// ---- dv/gpp_port_tb.sv ----
// self-checking bench for the pulse/debounce port
// assumes short timing parameters and the equipment model
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      bad_count++; \
      $display("Error at %0t got %h exp %h", $time, (a), (b)); \
    end \
  end

module gpp_port_tb;
  import gpp_pkg::*;
  localparam int MINP = 10;
  localparam int TOG = 6;
  localparam int HALF = 4;
  localparam logic [7:0] PULL = 8'hf0;
  typedef struct packed {
    gpp_req_t req;
    logic lvl;
    logic oe;
  } gpp_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic sleep = 1'b0;
  logic poff = 1'b0;
  gpp_req_t cmd = '0;
  logic [7:0] drv = 8'h00;
  logic [7:0] trig, ev, lvl, oe, pin;
  logic ent, ext;
  int bad_count = 0;
  int comparisons = 0;
  int evn [8];
  int entn = 0;
  int extn = 0;
  // channels 0-3 are reserved in this variant
  gpp_row_t rows [8] = '{
    '{'{1'b1, 3'h4, GPP_CMD_RISE}, 1'b1, 1'b1},
    '{'{1'b1, 3'h4, GPP_CMD_RISE}, 1'b1, 1'b1},
    '{'{1'b1, 3'h4, GPP_CMD_FALL}, 1'b0, 1'b1},
    '{'{1'b1, 3'h4, GPP_CMD_FALL}, 1'b0, 1'b1},
    '{'{1'b1, 3'h5, GPP_CMD_FALL}, 1'b0, 1'b1},
    '{'{1'b1, 3'h5, GPP_CMD_RISE}, 1'b1, 1'b1},
    '{'{1'b1, 3'h2, GPP_CMD_RISE}, 1'b0, 1'b0},
    '{'{1'b1, 3'h3, GPP_CMD_CONT}, 1'b0, 1'b0}
  };

  gpp_port #(
    .MIN_PULSE_CYC(MINP),
    .TOGGLE_CYC(TOG),
    .CONT_HALF_CYC(HALF),
    .RSVD_VARIANT(1'b1),
    .SLEEP_VARIANT(1'b1)
  ) dut_u (
    .CLK(clk), .RST(rst), .CE(ce), .TRIG_IN(trig), .CMD(cmd),
    .SLEEP(sleep), .POWER_OFF(poff), .TRIG_EVENT(ev),
    .OUT_LEVEL(lvl), .OUT_OE(oe),
    .SLEEP_ENTER_REQ(ent), .SLEEP_EXIT_REQ(ext)
  );

  gpp_equip #(.PULL(PULL)) equip_u (
    .clk(clk), .drive_mask(drv), .out_level(lvl), .out_oe(oe),
    .trig_line(trig), .pin_level(pin)
  );

  always #5 clk = ~clk;

  // tally one-cycle event pulses per channel, mid-cycle to avoid races
  always @(negedge clk)
  begin
    for (int i = 0; i < 8; i++)
      if (ev[i] === 1'b1) evn[i]++;
    if (ent === 1'b1) entn++;
    if (ext === 1'b1) extn++;
  end

  task automatic send(input logic [2:0] ch, input gpp_cmd_t c);
    @(posedge clk);
    cmd <= '{1'b1, ch, c};
    @(posedge clk);
    cmd <= '0;
    #1;
  endtask

  // width counts clock samples the line stays high
  task automatic pulse(input int ch, input int w);
    @(posedge clk);
    drv[ch] <= 1'b1;
    repeat (w) @(posedge clk);
    drv[ch] <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic tog_chk(input logic [2:0] ch, input logic pre);
    send(ch, pre ? GPP_CMD_RISE : GPP_CMD_FALL);
    send(ch, GPP_CMD_TOG);
    `CHK(lvl[ch], ~pre)
    repeat (TOG - 1) @(posedge clk);
    #1;
    `CHK(lvl[ch], ~pre)
    @(posedge clk);
    #1;
    `CHK(lvl[ch], pre)
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog, well past the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end

  // ---------------------------------------------
  // stimulus
  // ---------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK({lvl, oe, ev}, 24'h000000)
    foreach (rows[k])
    begin
      send(rows[k].req.chan, rows[k].req.cmd);
      `CHK(lvl[rows[k].req.chan], rows[k].lvl)
      `CHK(oe[rows[k].req.chan], rows[k].oe)
    end
    // one sample short is bounce
    pulse(5, MINP - 1);
    `CHK(evn[5], 0)
    // odd channels hold long: a held line fires once
    for (int i = 0; i < 8; i++)
    begin
      pulse(i, (i % 2) ? 3 * MINP : MINP);
      `CHK(evn[i], 1)
    end
    `CHK(entn, 1)
    `CHK(extn, 1)
    tog_chk(3'h6, 1'b0);
    tog_chk(3'h7, 1'b1);
    // line was low, so the start drives it high, then flips per half period
    send(3'h4, GPP_CMD_CONT);
    `CHK(lvl[4], 1'b1)
    for (int k = 1; k < 5; k++)
    begin
      repeat (HALF) @(posedge clk);
      #1;
      `CHK(lvl[4], ~k[0])
    end
    send(3'h4, GPP_CMD_FALL);
    repeat (2 * HALF) @(posedge clk);
    #1;
    `CHK(lvl[4], 1'b0)
    // clock enable low freezes the pulse timer mid-pulse
    send(3'h6, GPP_CMD_TOG);
    @(posedge clk);
    ce <= 1'b0;
    repeat (2 * TOG) @(posedge clk);
    ce <= 1'b1;
    #1;
    `CHK(lvl[6], 1'b1)
    repeat (TOG) @(posedge clk);
    #1;
    `CHK(lvl[6], 1'b0)
    // sleep, then power-off; a command meanwhile is refused
    for (int s = 0; s < 2; s++)
    begin
      send(3'h5, GPP_CMD_RISE);
      @(posedge clk);
      sleep <= (s == 0);
      poff <= (s == 1);
      send(3'h6, GPP_CMD_RISE);
      `CHK(oe, 8'h00)
      `CHK(pin, PULL)
      @(posedge clk);
      sleep <= 1'b0;
      poff <= 1'b0;
    end
    // reset in mid-run stops a running toggle and releases all lines
    send(3'h4, GPP_CMD_CONT);
    `CHK(oe[4], 1'b1)
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK({lvl, oe, ev}, 24'h000000)
    repeat (2 * HALF) @(posedge clk);
    #1;
    `CHK({lvl, oe}, 16'h0000)
    results();
  end
endmodule

`default_nettype wire
